// [rtl/setp_defines.vh]
`ifndef SETP_DEFINES_VH
`define SETP_DEFINES_VH
`define SETP_AW 8
`define SETP_A_CFG 8'h00
`define SETP_A_CTRL 8'h01
`define SETP_A_COUNT 8'h02
`define SETP_A_STATE 8'h03
`define SETP_A_PINS 8'h04
`define SETP_A_OUT 8'h05
`define SETP_A_FLAG 8'h06
`define SETP_A_IEN 8'h07
`define SETP_A_DEN 8'h08
`define SETP_A_MODE 8'h09
`define SETP_G_MATCH 4'h1
`define SETP_G_CAPEV 4'h2
`define SETP_G_EVST 4'h4
`define SETP_G_EVCT 4'h6
`define SETP_G_OSET 4'h8
`define SETP_G_OCLR 4'h9
`define SETP_CFG_UNIFY 0
`define SETP_CFG_AUTOL 1
`define SETP_CFG_AUTOH 2
`define SETP_CFG_CKIN 3
`define SETP_CFG_CKSEL 6:4
`define SETP_CT_HALT 0
`define SETP_CT_STOP 1
`define SETP_CT_BIDIR 2
`define SETP_CT_CLR 3
`define SETP_CT_HI 16
`define SETP_CTRL_RST 32'h0001_0001
`define SETP_EV_MSEL 3:0
`define SETP_EV_HSEL 4
`define SETP_EV_IOOUT 5
`define SETP_EV_IOSEL 9:6
`define SETP_EV_IOC 11:10
`define SETP_EV_COMB 13:12
`define SETP_EV_STLD 14
`define SETP_EV_STV 19:15
`define SETP_EV_DIR 21:20
`define SETP_EV_HOLD 22
`define SETP_EV_LIM 23
`define SETP_EV_HALT 24
`define SETP_EV_STOP 25
`define SETP_EV_START 26
`define SETP_EVW 27
`define SETP_IOC_LOW 2'h0
`define SETP_IOC_RISE 2'h1
`define SETP_IOC_FALL 2'h2
`define SETP_IOC_HIGH 2'h3
`define SETP_CMB_OR 2'h0
`define SETP_CMB_MATCH 2'h1
`define SETP_CMB_IO 2'h2
`define SETP_CMB_AND 2'h3
`define SETP_DIR_ANY 2'h0
`define SETP_DIR_UP 2'h1
`define SETP_DIR_DOWN 2'h2
`define SETP_IOVW 16
`endif

// [rtl/setp_timer.v]
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "setp_defines.vh"
`include "setp_ctrl_mask.vh"
module setp_timer #(
  parameter NEV = 16,
  parameter NMR = 16,
  parameter NIN = 8,
  parameter NOUT = 10,
  parameter NST = 32,
  parameter SW = 5
) (
  input wire clk,
  input wire arst_n,
  input wire [`SETP_AW-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata_r,
  input wire [NIN-1:0] pin_in,
  output reg [NOUT-1:0] pin_out_r,
  output reg irq_r,
  output reg dma_req_r
);
  reg [31:0] cfg_r;
  reg [31:0] ctrl_r;
  reg [31:0] cnt_r;
  reg [1:0] dir_r;
  reg [2*SW-1:0] st_r;
  reg [NEV-1:0] flag_r;
  reg [NEV-1:0] ien_r;
  reg [NEV-1:0] den_r;
  reg [NMR-1:0] mode_r;
  reg [NEV-1:0] pend_r;
  reg [NIN-1:0] in_q_r;
  reg [NOUT-1:0] out_q_r;
  reg [31:0] mr_r [0:NMR-1];
  reg [NEV-1:0] capev_r [0:NMR-1];
  reg [NST-1:0] evst_r [0:NEV-1];
  reg [`SETP_EVW-1:0] evct_r [0:NEV-1];
  reg [NEV-1:0] oset_r [0:NOUT-1];
  reg [NEV-1:0] oclr_r [0:NOUT-1];

  wire [3:0] ga = addr[7:4];
  wire [3:0] gi = addr[3:0];
  wire unify = cfg_r[`SETP_CFG_UNIFY];
  wire [`SETP_IOVW-1:0] iv = {{(`SETP_IOVW-NIN){1'b0}}, pin_in};
  wire [`SETP_IOVW-1:0] ivq = {{(`SETP_IOVW-NIN){1'b0}}, in_q_r};
  wire [`SETP_IOVW-1:0] ov = {{(`SETP_IOVW-NOUT){1'b0}}, pin_out_r};
  wire [`SETP_IOVW-1:0] ovq = {{(`SETP_IOVW-NOUT){1'b0}}, out_q_r};
  wire [1:0] halt = {ctrl_r[`SETP_CT_HI+`SETP_CT_HALT], ctrl_r[`SETP_CT_HALT]};
  wire [1:0] stop = {ctrl_r[`SETP_CT_HI+`SETP_CT_STOP], ctrl_r[`SETP_CT_STOP]};
  wire [1:0] bidir = {ctrl_r[`SETP_CT_HI+`SETP_CT_BIDIR], ctrl_r[`SETP_CT_BIDIR]};
  // Input clock mode counts on a rising edge of the chosen pin
  wire tick = cfg_r[`SETP_CFG_CKIN] ?
    (pin_in[cfg_r[`SETP_CFG_CKSEL]] & ~in_q_r[cfg_r[`SETP_CFG_CKSEL]]) : 1'b1;
  wire [1:0] run = ~halt & ~stop & {2{tick}};

  // Returns {dir, count}; dir 1 means counting down
  function [32:0] step;
    input [31:0] c;
    input d;
    input bd;
    input lim;
    begin
      if (!bd)
        step = {1'b0, lim ? 32'h0000_0000 : c + 32'h0000_0001};
      else if (!d && lim)
        step = {1'b1, c - 32'h0000_0001};
      else if (d && c == 32'h0000_0000)
        step = {1'b0, c + 32'h0000_0001};
      else
        step = {d, d ? c - 32'h0000_0001 : c + 32'h0000_0001};
    end
  endfunction

  reg [NEV-1:0] fire;
  reg [NEV-1:0] pend_nxt;
  reg [`SETP_EVW-1:0] ec;
  reg eh;
  reg mt;
  reg io;
  reg ioc;
  reg dq;
  reg [31:0] mv;
  integer j;
  // Event evaluation
  always @* begin
    fire = {NEV{1'b0}};
    pend_nxt = pend_r;
    ec = {`SETP_EVW{1'b0}};
    eh = 1'b0;
    mt = 1'b0;
    io = 1'b0;
    ioc = 1'b0;
    dq = 1'b0;
    mv = 32'h0000_0000;
    for (j = 0; j < NEV; j = j + 1) begin
      ec = evct_r[j];
      eh = ec[`SETP_EV_HSEL] & ~unify;
      mv = mr_r[ec[`SETP_EV_MSEL]];
      // A match counts only on a counting tick so slow input clocks fire once
      if (mode_r[ec[`SETP_EV_MSEL]])
        mt = 1'b0;
      else if (unify)
        mt = run[0] && cnt_r == mv;
      else if (eh)
        mt = run[1] && cnt_r[31:16] == mv[31:16];
      else
        mt = run[0] && cnt_r[15:0] == mv[15:0];
      io = ec[`SETP_EV_IOOUT] ? ov[ec[`SETP_EV_IOSEL]] : iv[ec[`SETP_EV_IOSEL]];
      dq = ec[`SETP_EV_IOOUT] ? ovq[ec[`SETP_EV_IOSEL]] : ivq[ec[`SETP_EV_IOSEL]];
      case (ec[`SETP_EV_IOC])
        `SETP_IOC_LOW: ioc = ~io;
        `SETP_IOC_RISE: ioc = io & ~dq;
        `SETP_IOC_FALL: ioc = ~io & dq;
        `SETP_IOC_HIGH: ioc = io;
        default: ioc = 1'b0;
      endcase
      if (ec[`SETP_EV_HOLD]) begin
        pend_nxt[j] = pend_r[j] | mt;
        mt = pend_nxt[j];
      end
      case (ec[`SETP_EV_COMB])
        `SETP_CMB_OR: fire[j] = mt | ioc;
        `SETP_CMB_MATCH: fire[j] = mt;
        `SETP_CMB_IO: fire[j] = ioc;
        `SETP_CMB_AND: fire[j] = mt & ioc;
        default: fire[j] = 1'b0;
      endcase
      dq = eh ? dir_r[1] : dir_r[0];
      case (ec[`SETP_EV_DIR])
        `SETP_DIR_UP: fire[j] = fire[j] & ~dq;
        `SETP_DIR_DOWN: fire[j] = fire[j] & dq;
        default: fire[j] = fire[j];
      endcase
      // Halted counter blocks its events; state mask gates the rest
      fire[j] = fire[j] & ~halt[eh] &
        evst_r[j][eh ? st_r[2*SW-1:SW] : st_r[SW-1:0]];
      if (fire[j])
        pend_nxt[j] = 1'b0;
    end
  end

  reg [1:0] lim;
  reg [1:0] ehalt;
  reg [1:0] estop;
  reg [1:0] estart;
  reg [1:0] stld;
  reg [SW-1:0] stv0;
  reg [SW-1:0] stv1;
  integer e;
  // Fired events gathered per counter
  always @* begin
    lim = 2'b00;
    ehalt = 2'b00;
    estop = 2'b00;
    estart = 2'b00;
    stld = 2'b00;
    stv0 = st_r[SW-1:0];
    stv1 = st_r[2*SW-1:SW];
    for (e = 0; e < NEV; e = e + 1) begin
      if (fire[e]) begin
        if (evct_r[e][`SETP_EV_HSEL] & ~unify) begin
          lim[1] = lim[1] | evct_r[e][`SETP_EV_LIM];
          ehalt[1] = ehalt[1] | evct_r[e][`SETP_EV_HALT];
          estop[1] = estop[1] | evct_r[e][`SETP_EV_STOP];
          estart[1] = estart[1] | evct_r[e][`SETP_EV_START];
          if (evct_r[e][`SETP_EV_STLD])
            stv1 = evct_r[e][`SETP_EV_STV];
        end else begin
          lim[0] = lim[0] | evct_r[e][`SETP_EV_LIM];
          ehalt[0] = ehalt[0] | evct_r[e][`SETP_EV_HALT];
          estop[0] = estop[0] | evct_r[e][`SETP_EV_STOP];
          estart[0] = estart[0] | evct_r[e][`SETP_EV_START];
          if (evct_r[e][`SETP_EV_STLD])
            stv0 = evct_r[e][`SETP_EV_STV];
        end
      end
    end
    // Match 0 as limit needs no event programmed
    if (cfg_r[`SETP_CFG_AUTOL] && !mode_r[0])
      lim[0] = lim[0] | (unify ? cnt_r == mr_r[0] : cnt_r[15:0] == mr_r[0][15:0]);
    if (cfg_r[`SETP_CFG_AUTOH] && !mode_r[0] && !unify)
      lim[1] = lim[1] | cnt_r[31:16] == mr_r[0][31:16];
  end

  reg [31:0] cnt_nxt;
  reg [1:0] dir_nxt;
  reg [32:0] s0;
  reg [32:0] s1;
  always @* begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    // Split mode must not see the upper half when testing for zero
    s0 = step(unify ? cnt_r : {16'h0000, cnt_r[15:0]}, dir_r[0], bidir[0], lim[0]);
    s1 = step({16'h0000, cnt_r[31:16]}, dir_r[1], bidir[1], lim[1]);
    if (unify) begin
      if (run[0]) begin
        cnt_nxt = s0[31:0];
        dir_nxt[0] = s0[32];
      end
    end else begin
      if (run[0]) begin
        cnt_nxt[15:0] = s0[15:0];
        dir_nxt[0] = s0[32];
      end
      if (run[1]) begin
        cnt_nxt[31:16] = s1[15:0];
        dir_nxt[1] = s1[32];
      end
    end
  end

  wire wctrl = wr && addr == `SETP_A_CTRL;
  integer k;
  integer m;
  reg [NOUT-1:0] oset;
  reg [NOUT-1:0] oclr;
  // Per output: any fired event selecting set or clear
  always @* begin
    oset = {NOUT{1'b0}};
    oclr = {NOUT{1'b0}};
    for (m = 0; m < NOUT; m = m + 1) begin
      oset[m] = |(fire & oset_r[m]);
      oclr[m] = |(fire & oclr_r[m]);
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= 32'h0000_0000;
      ctrl_r <= `SETP_CTRL_RST;
      cnt_r <= 32'h0000_0000;
      dir_r <= 2'b00;
      st_r <= {2*SW{1'b0}};
      flag_r <= {NEV{1'b0}};
      ien_r <= {NEV{1'b0}};
      den_r <= {NEV{1'b0}};
      mode_r <= {NMR{1'b0}};
      pend_r <= {NEV{1'b0}};
      in_q_r <= {NIN{1'b0}};
      out_q_r <= {NOUT{1'b0}};
      pin_out_r <= {NOUT{1'b0}};
      irq_r <= 1'b0;
      dma_req_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      for (k = 0; k < NEV; k = k + 1) begin
        evst_r[k] <= {NST{1'b0}};
        evct_r[k] <= {`SETP_EVW{1'b0}};
      end
      for (k = 0; k < NMR; k = k + 1) begin
        mr_r[k] <= 32'h0000_0000;
        capev_r[k] <= {NEV{1'b0}};
      end
      for (k = 0; k < NOUT; k = k + 1) begin
        oset_r[k] <= {NEV{1'b0}};
        oclr_r[k] <= {NEV{1'b0}};
      end
    end else begin
      in_q_r <= pin_in;
      out_q_r <= pin_out_r;
      pend_r <= pend_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      if (wr && addr == `SETP_A_CFG)
        cfg_r <= wdata;
      if (wr && addr == `SETP_A_COUNT)
        cnt_r <= wdata;
      if (wctrl && wdata[`SETP_CT_CLR]) begin
        cnt_r[15:0] <= 16'h0000;
        dir_r[0] <= 1'b0;
      end
      if (wctrl && wdata[`SETP_CT_HI+`SETP_CT_CLR]) begin
        cnt_r[31:16] <= 16'h0000;
        dir_r[1] <= 1'b0;
      end
      // Event actions are applied after a software write so they win
      if (wctrl)
        ctrl_r <= wdata & `SETP_CTRL_MASK;
      for (k = 0; k < 2; k = k + 1) begin
        if (ehalt[k])
          ctrl_r[`SETP_CT_HI*k+`SETP_CT_HALT] <= 1'b1;
        if (estop[k])
          ctrl_r[`SETP_CT_HI*k+`SETP_CT_STOP] <= 1'b1;
        else if (estart[k])
          ctrl_r[`SETP_CT_HI*k+`SETP_CT_STOP] <= 1'b0;
      end
      if (wr && addr == `SETP_A_STATE)
        st_r <= wdata[2*SW-1:0];
      else
        st_r <= {stv1, stv0};
      if (wr && addr == `SETP_A_IEN)
        ien_r <= wdata[NEV-1:0];
      if (wr && addr == `SETP_A_DEN)
        den_r <= wdata[NEV-1:0];
      if (wr && addr == `SETP_A_MODE)
        mode_r <= wdata[NMR-1:0];
      // Write one clears; a new event in the same cycle keeps its flag
      flag_r <= (flag_r & ~((wr && addr == `SETP_A_FLAG) ? wdata[NEV-1:0] : {NEV{1'b0}}))
        | fire;
      irq_r <= |((flag_r | fire) & ien_r);
      dma_req_r <= |(fire & den_r);
      if (wr && ga == `SETP_G_EVST && gi < NEV)
        evst_r[gi] <= wdata[NST-1:0];
      if (wr && ga == `SETP_G_EVCT && gi < NEV)
        evct_r[gi] <= wdata[`SETP_EVW-1:0];
      for (k = 0; k < NMR; k = k + 1) begin
        if (wr && ga == `SETP_G_MATCH && gi == k)
          mr_r[k] <= wdata;
        if (mode_r[k] && |(fire & capev_r[k]))
          mr_r[k] <= cnt_r;
        if (wr && ga == `SETP_G_CAPEV && gi == k)
          capev_r[k] <= wdata[NEV-1:0];
      end
      if (wr && addr == `SETP_A_OUT)
        pin_out_r <= wdata[NOUT-1:0];
      for (k = 0; k < NOUT; k = k + 1) begin
        if (wr && ga == `SETP_G_OSET && gi == k)
          oset_r[k] <= wdata[NEV-1:0];
        if (wr && ga == `SETP_G_OCLR && gi == k)
          oclr_r[k] <= wdata[NEV-1:0];
        // Both selected means toggle; period set by limit, duty by match
        if (oset[k] && oclr[k])
          pin_out_r[k] <= ~pin_out_r[k];
        else if (oset[k])
          pin_out_r[k] <= 1'b1;
        else if (oclr[k])
          pin_out_r[k] <= 1'b0;
      end
      rdata_r <= 32'h0000_0000;
      if (rd) begin
        if (addr == `SETP_A_CFG)
          rdata_r <= cfg_r;
        else if (addr == `SETP_A_CTRL)
          rdata_r <= ctrl_r;
        else if (addr == `SETP_A_COUNT)
          rdata_r <= cnt_r;
        else if (addr == `SETP_A_STATE)
          rdata_r <= {{(32-2*SW){1'b0}}, st_r};
        else if (addr == `SETP_A_PINS)
          rdata_r <= {ov, iv};
        else if (addr == `SETP_A_OUT)
          rdata_r <= {{(32-NOUT){1'b0}}, pin_out_r};
        else if (addr == `SETP_A_FLAG)
          rdata_r <= {{(32-NEV){1'b0}}, flag_r};
        else if (addr == `SETP_A_IEN)
          rdata_r <= {{(32-NEV){1'b0}}, ien_r};
        else if (addr == `SETP_A_DEN)
          rdata_r <= {{(32-NEV){1'b0}}, den_r};
        else if (addr == `SETP_A_MODE)
          rdata_r <= {{(32-NMR){1'b0}}, mode_r};
        else if (ga == `SETP_G_MATCH && gi < NMR)
          rdata_r <= mr_r[gi];
        else if (ga == `SETP_G_CAPEV && gi < NMR)
          rdata_r <= {{(32-NEV){1'b0}}, capev_r[gi]};
        else if (ga == `SETP_G_EVST && gi < NEV)
          rdata_r <= evst_r[gi];
        else if (ga == `SETP_G_EVCT && gi < NEV)
          rdata_r <= {{(32-`SETP_EVW){1'b0}}, evct_r[gi]};
        else if (ga == `SETP_G_OSET && gi < NOUT)
          rdata_r <= {{(32-NEV){1'b0}}, oset_r[gi]};
        else if (ga == `SETP_G_OCLR && gi < NOUT)
          rdata_r <= {{(32-NEV){1'b0}}, oclr_r[gi]};
      end
    end
  end
endmodule

// [rtl/setp_ctrl_mask.vh]
`ifndef SETP_CTRL_MASK_DEFINES_VH
`define SETP_CTRL_MASK_DEFINES_VH
// Clear bits are pulses; every other control bit is kept as written
`define SETP_CTRL_MASK 32'hFFF7_FFF7
`endif

// [testbench/setp_timer_checker.sv]
`timescale 1ns/10ps
`include "setp_defines.vh"
module setp_timer_checker (
  input wire clk,
  input wire arst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata_r,
  input wire [7:0] pin_in,
  input wire [9:0] pin_out_r,
  input wire irq_r,
  input wire dma_req_r
);
  reg used_r;
  reg ien_r;
  reg den_r;
  // Shadow of the enables, so requests can be tied to their permission
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      used_r <= 1'b0;
      ien_r <= 1'b0;
      den_r <= 1'b0;
    end else begin
      used_r <= used_r | wr;
      if (wr && addr == `SETP_A_IEN) ien_r <= |wdata;
      if (wr && addr == `SETP_A_DEN) den_r <= |wdata;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_quiet_reset: assert property (
    !used_r |-> pin_out_r == 10'h000 && !irq_r && !dma_req_r)
    else $error("outputs active before any configuration");
  a_rdata_idle: assert property (
    rdata_r != 32'h0 |-> $past(rd))
    else $error("read data outside the read slot");
  a_pins_read: assert property (
    rd && addr == `SETP_A_PINS |=>
      rdata_r == {6'h00, $past(pin_out_r), 8'h00, $past(pin_in)})
    else $error("pin status read wrong");
  a_unmapped_zero: assert property (
    rd && addr >= 8'hA0 |=> rdata_r == 32'h0)
    else $error("unmapped read not zero");
  a_out_write: assert property (
    wr && addr == `SETP_A_OUT |=> pin_out_r == $past(wdata[9:0]))
    else $error("output write not applied");
  a_irq_off: assert property (
    wr && addr == `SETP_A_IEN && wdata == 32'h0 |=> ##1 !irq_r [*3])
    else $error("interrupt stays with enables off");
  a_irq_enabled: assert property (
    irq_r |-> ien_r || $past(ien_r))
    else $error("interrupt without enable");
  a_dma_enabled: assert property (
    dma_req_r |-> den_r || $past(den_r))
    else $error("dma request without enable");
  c_dma: cover property (dma_req_r);
  c_irq: cover property (irq_r);
  c_out: cover property ($changed(pin_out_r));
endmodule
bind setp_timer setp_timer_checker i_chk (.clk(clk), .arst_n(arst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .pin_in(pin_in),
  .pin_out_r(pin_out_r), .irq_r(irq_r), .dma_req_r(dma_req_r));

// [testbench/setp_pins.sv]
`timescale 1ns/10ps
module setp_pins (
  input wire clk,
  input wire [7:0] lvl,
  output reg [7:0] pin_in
);
  // Registered like a pad synchroniser, so edges land one cycle late
  initial pin_in = 8'h00;
  always @(posedge clk) begin
    pin_in <= lvl;
  end
endmodule

// [testbench/tb_setp_timer.sv]
`timescale 1ns/10ps
`include "setp_defines.vh"
module tb_setp_timer;
  localparam P = 20;
  localparam N = 7;
  reg clk;
  reg arst_n;
  reg [7:0] addr;
  reg [31:0] wdata;
  reg wr;
  reg rd;
  reg [7:0] lvl;
  wire [31:0] rdata_r;
  wire [7:0] pin_in;
  wire [9:0] pin_out_r;
  wire irq_r;
  wire dma_req_r;
  integer fail_count;
  integer n_tests;
  integer dma_n;
  integer i;
  integer t;
  reg [31:0] v;
  reg [31:0] w;
  setp_timer i_setp_timer (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_r(rdata_r), .pin_in(pin_in), .pin_out_r(pin_out_r),
    .irq_r(irq_r), .dma_req_r(dma_req_r));
  setp_pins i_setp_pins (.clk(clk), .lvl(lvl), .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dma_req_r === 1'b1) dma_n = dma_n + 1;
  end
  task conclude;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rget(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata_r;
    end
  endtask
  task rreg(input [7:0] a, input [31:0] exp);
    begin
      rget(a);
      chk(v, exp);
    end
  endtask
  // Counts edges until the output bit reaches lv; t is the interval
  task wait_out(input integer b, input lv);
    begin
      t = 0;
      while (pin_out_r[b] !== lv && t < 200) begin
        @(posedge clk);
        #1 t = t + 1;
      end
      if (t >= 200) begin
        chk(t, 0);
        conclude;
      end
    end
  endtask
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    lvl = 8'h00;
    arst_n = 1'b0;
    fail_count = 0;
    n_tests = 0;
    dma_n = 0;
    v = $urandom(32'hC9DBF49D);
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rreg(`SETP_A_CTRL, 32'h0001_0001);
    rreg(`SETP_A_COUNT, 32'h0);
    rreg(`SETP_A_STATE, 32'h0);
    wreg(8'h10, P);
    wreg(8'h11, N);
    wreg(`SETP_A_MODE, 32'h4);
    wreg(8'h22, 32'h1);
    wreg(8'h40, 32'h1);
    wreg(8'h60, 32'hD001);
    wreg(8'h80, 32'h1);
    wreg(`SETP_A_IEN, 32'h1);
    wreg(`SETP_A_DEN, 32'h1);
    wreg(`SETP_A_CFG, 32'h2);
    wreg(`SETP_A_CTRL, 32'h0001_0008);
    wait_out(0, 1'b1);
    chk(irq_r, 1);
    rreg(`SETP_A_STATE, 32'h1);
    rreg(8'h12, N);
    rreg(`SETP_A_FLAG, 32'h1);
    // Count wraps past N again; event must stay blocked in state 1
    repeat (3 * P) @(posedge clk);
    chk(dma_n, 1);
    wreg(`SETP_A_FLAG, 32'hFFFF);
    wreg(`SETP_A_IEN, 32'h0);
    wreg(8'h60, 32'h0010_1001);
    wreg(8'h90, 32'h1);
    wreg(`SETP_A_STATE, 32'h0);
    for (i = 0; i < 2; i = i + 1) begin
      wreg(`SETP_A_CTRL, i ? 32'h0001_0004 : 32'h0001_0000);
      wait_out(0, ~pin_out_r[0]);
      wait_out(0, ~pin_out_r[0]);
      chk(t, i ? 2 * P : P + 1);
    end
    wreg(8'h40, 32'h0);
    wreg(8'h81, 32'h2);
    for (i = 0; i < 4; i = i + 1) begin
      lvl <= i[0] ? 8'h00 : 8'h08;
      wreg(8'h41, 32'h0);
      wreg(8'h61, 32'h20C0 | (i << 10) | (i == 3 ? 32'h0100_0000 : 32'h0));
      wreg(`SETP_A_OUT, 32'h0);
      wreg(8'h41, 32'hFFFF_FFFF);
      repeat (3) @(posedge clk);
      chk(pin_out_r[1], 0);
      lvl <= i[0] ? 8'h08 : 8'h00;
      wait_out(1, 1'b1);
    end
    rget(`SETP_A_COUNT);
    repeat (5) @(posedge clk);
    rreg(`SETP_A_COUNT, v);
    wreg(8'h41, 32'h0);
    wreg(`SETP_A_CFG, 32'h58);
    wreg(`SETP_A_CTRL, 32'h0001_0008);
    repeat (7) begin
      lvl <= 8'h20;
      repeat (2) @(posedge clk);
      lvl <= 8'h00;
      repeat (2) @(posedge clk);
    end
    rreg(`SETP_A_COUNT, 32'h7);
    // Held match waits for pin 4 high, then stops; pin 4 low restarts
    wreg(8'h62, 32'h0240_3D01);
    wreg(8'h42, 32'hFFFF_FFFF);
    wreg(8'h63, 32'h0400_2100);
    wreg(8'h43, 32'hFFFF_FFFF);
    wreg(8'h82, 32'h4);
    wreg(`SETP_A_OUT, 32'h0);
    wreg(`SETP_A_CFG, 32'h1);
    wreg(`SETP_A_CTRL, 32'h0001_0008);
    repeat (20) @(posedge clk);
    chk(pin_out_r[2], 0);
    lvl <= 8'h10;
    wait_out(2, 1'b1);
    rget(`SETP_A_COUNT);
    w = v;
    rreg(`SETP_A_COUNT, w);
    lvl <= 8'h00;
    repeat (4) @(posedge clk);
    rget(`SETP_A_COUNT);
    chk(v > w, 1);
    // Unified count carries into the upper half
    wreg(`SETP_A_COUNT, 32'h0000_FFFF);
    rreg(`SETP_A_COUNT, 32'h0001_0000);
    for (i = 3; i < 16; i = i + 1) begin
      w = $urandom;
      lvl <= w[7:0];
      wreg({4'h1, i[3:0]}, w);
      rreg({4'h1, i[3:0]}, w);
      rreg(`SETP_A_PINS, {6'h00, pin_out_r, 8'h00, w[7:0]});
    end
    rreg(8'hF0, 32'h0);
    conclude;
  end
endmodule
